//--- hdl/usbdc_cmd_decoder.sv
`timescale 1ns/100ps
`include "usbdc_defs.svh"

module usbdc_cmd_decoder
  import usbdc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic data_wr,
  input wire logic [15:0] wdata,
  input wire logic data_rd,
  input wire logic bus_reset,
  input wire logic status_ack,
  input wire logic lock_req,
  input wire logic err_wr,
  input wire logic [3:0] err_idx,
  input wire logic [7:0] err_code,
  output logic [15:0] rdata_q,
  output logic setup_ack_q,
  output logic [6:0] active_addr_q,
  output logic device_enable_q,
  output logic regs_locked_q,
  output logic [127:0] ep_cfg_q,
  output logic [15:0] fifo_enabled,
  output logic [15:0] endpoint_direction,
  output logic [15:0] dma_write_dir,
  output logic [15:0] double_buffered,
  output logic [15:0] isochronous_select,
  output logic [63:0] fifo_size_code,
  output logic fifo_alloc_start_q,
  output logic fifo_invalidate_q
);

  usbdc_state_t st_q;
  usbdc_state_t st_d;
  logic cfg_wr;
  logic wr_word;
  logic rd_word;
  logic [7:0] cfg_sel;
  logic [7:0] err_sel;

  // word accesses needed for a register of the given byte count
  function automatic logic [1:0] cmd_words(input logic [10:0] nbytes);
    logic [10:0] words;
    words = (nbytes + 11'h001) >> 1;
    cmd_words = words[1:0];
  endfunction : cmd_words

  //////////////////////////////////////////////////////////////////////////////
  // data phase strobes and selected read values
  assign wr_word = (st_q.phase == USBDC_WR) && data_wr;
  assign rd_word = (st_q.phase == USBDC_RD) && data_rd;
  assign cfg_wr = wr_word && (st_q.cmd[7:4] == `USBDC_GRP_CFG_WR) && !st_q.locked;
  assign cfg_sel = ep_cfg_q[cmd_code[3:0]*8 +: 8];
  assign err_sel = st_q.err_codes[cmd_code[3:0]];

  //////////////////////////////////////////////////////////////////////////////
  // next state of the decoder
  always_comb begin
    st_d = st_q;
    st_d.setup_ack = 1'b0;

    // error codes reported by the endpoint engines
    if (err_wr) begin
      st_d.err_codes[err_idx] = err_code;
    end

    // the pending address goes live when the empty status packet is acknowledged
    if (status_ack && st_q.addr_pending) begin
      st_d.active_addr = st_q.addr_reg[`USBDC_ADDR_MSB:0];
      st_d.dev_en = st_q.addr_reg[`USBDC_ADDR_EN_BIT];
      st_d.addr_pending = 1'b0;
    end

    // bus reset: internal address only, the visible register is kept
    if (bus_reset) begin
      st_d.active_addr = `USBDC_BUS_RESET_ADDR;
      st_d.dev_en = 1'b1;
      st_d.addr_pending = 1'b0;
    end

    // data word written for the current command
    if (wr_word) begin
      st_d.words_left = st_q.words_left - 2'h1;
      if (st_q.words_left == 2'h1) begin
        st_d.phase = USBDC_IDLE;
      end
      case (st_q.cmd)
        `USBDC_CMD_UNLOCK: begin
          st_d.locked = 1'b0;
        end
        `USBDC_CMD_ADDR_WR: begin
          if (!st_q.locked) begin
            st_d.addr_reg = wdata[7:0];
            st_d.addr_pending = 1'b1;
          end
        end
        default: begin
          st_d.locked = st_q.locked;
        end
      endcase
    end

    // data word read for the current command
    if (rd_word) begin
      st_d.words_left = st_q.words_left - 2'h1;
      if (st_q.words_left == 2'h1) begin
        st_d.phase = USBDC_IDLE;
      end
    end

    // a new command code always restarts the decoder
    if (cmd_wr) begin
      st_d.cmd = cmd_code;
      st_d.phase = USBDC_IDLE;
      st_d.words_left = 2'h0;
      if (cmd_code == `USBDC_CMD_ACK_SETUP) begin
        st_d.setup_ack = 1'b1;
      end else if (cmd_code == `USBDC_CMD_UNLOCK || cmd_code == `USBDC_CMD_ADDR_WR
          || cmd_code[7:4] == `USBDC_GRP_CFG_WR) begin
        st_d.phase = USBDC_WR;
        st_d.words_left = cmd_words(`USBDC_REG_BYTES);
      end else if (cmd_code == `USBDC_CMD_ADDR_RD) begin
        st_d.phase = USBDC_RD;
        st_d.words_left = cmd_words(`USBDC_REG_BYTES);
        st_d.rdata = {8'h00, st_q.addr_reg};
      end else if (cmd_code[7:4] == `USBDC_GRP_CFG_RD) begin
        st_d.phase = USBDC_RD;
        st_d.words_left = cmd_words(`USBDC_REG_BYTES);
        st_d.rdata = {8'h00, cfg_sel};
      end else if (cmd_code[7:4] == `USBDC_GRP_ERR_RD) begin
        st_d.phase = USBDC_RD;
        st_d.words_left = cmd_words(`USBDC_REG_BYTES);
        st_d.rdata = {8'h00, err_sel};
      end
    end

    // lock request wins over an unlock in the same cycle
    if (lock_req) begin
      st_d.locked = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_q = st_q.rdata;
  assign setup_ack_q = st_q.setup_ack;
  assign active_addr_q = st_q.active_addr;
  assign device_enable_q = st_q.dev_en;
  assign regs_locked_q = st_q.locked;

  // endpoint configuration store and fifo allocation control
  usbdc_ep_cfg u_ep_cfg (
    .clk(clk),
    .arst_n(arst_n),
    .cfg_wr(cfg_wr),
    .cfg_idx(st_q.cmd[3:0]),
    .cfg_wdata(wdata[7:0]),
    .bus_reset(bus_reset),
    .ep_cfg_q(ep_cfg_q),
    .fifo_enabled(fifo_enabled),
    .endpoint_direction(endpoint_direction),
    .dma_write_dir(dma_write_dir),
    .double_buffered(double_buffered),
    .isochronous_select(isochronous_select),
    .fifo_size_code(fifo_size_code),
    .fifo_alloc_start_q(fifo_alloc_start_q),
    .fifo_invalidate_q(fifo_invalidate_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence setup_cmd_s;
    cmd_wr && cmd_code == `USBDC_CMD_ACK_SETUP;
  endsequence

  sequence addr_written_s;
    wr_word && st_q.cmd == `USBDC_CMD_ADDR_WR && !st_q.locked && !bus_reset;
  endsequence

  setup_pulse_a: assert property (setup_cmd_s |=> setup_ack_q
    && st_q.phase == USBDC_IDLE ##1 !setup_ack_q || $past(cmd_wr))
    else $error("acknowledge setup pulse wrong");

  err_read_a: assert property (cmd_wr && cmd_code[7:4] == `USBDC_GRP_ERR_RD
    |=> rdata_q == {8'h00, $past(err_sel)} && st_q.phase == USBDC_RD)
    else $error("error code read returned wrong word");

  unlock_a: assert property (wr_word && st_q.cmd == `USBDC_CMD_UNLOCK && !lock_req
    |=> !regs_locked_q) else $error("unlock did not lift the lock");

  one_word_a: assert property ((wr_word || rd_word) && !cmd_wr
    |=> st_q.phase == USBDC_IDLE) else $error("data phase longer than one word");

  upper_zero_a: assert property (st_q.phase == USBDC_RD |-> rdata_q[15:8] == 8'h00)
    else $error("upper byte of 8-bit read not zero");

  bus_reset_addr_a: assert property (bus_reset |=> active_addr_q == `USBDC_BUS_RESET_ADDR
    && device_enable_q && st_q.addr_reg == $past(st_q.addr_reg))
    else $error("bus reset handled address wrongly");

  addr_wait_a: assert property (addr_written_s ##1 (!status_ack && !bus_reset)
    |=> $stable(active_addr_q)) else $error("address switched before acknowledge");

  addr_switch_a: assert property (st_q.addr_pending && status_ack && !bus_reset
    |=> active_addr_q == $past(st_q.addr_reg[6:0])
    && device_enable_q == $past(st_q.addr_reg[7]))
    else $error("acknowledged address not applied");

  addr_read_a: assert property (cmd_wr && cmd_code == `USBDC_CMD_ADDR_RD
    |=> rdata_q[7:0] == $past(st_q.addr_reg)) else $error("address read wrong");

endmodule : usbdc_cmd_decoder

//--- hdl/usbdc_defs.svh
`ifndef USBDC_DEFS_SVH
`define USBDC_DEFS_SVH

// command codes
`define USBDC_CMD_ACK_SETUP 8'hF4
`define USBDC_CMD_UNLOCK 8'hB0
`define USBDC_CMD_ADDR_WR 8'hB6
`define USBDC_CMD_ADDR_RD 8'hB7
// command groups, compared against the upper nibble of the code
`define USBDC_GRP_CFG_WR 4'h2
`define USBDC_GRP_CFG_RD 4'h3
`define USBDC_GRP_ERR_RD 4'hA

// endpoint configuration fields
`define USBDC_CFG_EN_BIT 7
`define USBDC_CFG_DIR_BIT 6
`define USBDC_CFG_DBL_BIT 5
`define USBDC_CFG_ISO_BIT 4
`define USBDC_CFG_SIZE_MSB 3
`define USBDC_CFG_SIZE_LSB 0
`define USBDC_CFG_RESET 8'h00

// device address fields
`define USBDC_ADDR_EN_BIT 7
`define USBDC_ADDR_MSB 6
`define USBDC_ADDR_RESET 8'h00
`define USBDC_BUS_RESET_ADDR 7'h00

// endpoint sequence and transfer sizing
`define USBDC_FIRST_EP 4'h0
`define USBDC_LAST_EP 4'hF
`define USBDC_REG_BYTES 11'h001
`define USBDC_ERR_RESET 8'h00

`endif

//--- hdl/usbdc_ep_cfg.sv
`timescale 1ns/100ps
`include "usbdc_defs.svh"

module usbdc_ep_cfg
  import usbdc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_idx,
  input wire logic [7:0] cfg_wdata,
  input wire logic bus_reset,
  output logic [127:0] ep_cfg_q,
  output logic [15:0] fifo_enabled,
  output logic [15:0] endpoint_direction,
  output logic [15:0] dma_write_dir,
  output logic [15:0] double_buffered,
  output logic [15:0] isochronous_select,
  output logic [63:0] fifo_size_code,
  output logic fifo_alloc_start_q,
  output logic fifo_invalidate_q
);

  usbdc_epcfg_t st_q;
  usbdc_epcfg_t st_d;

  // true when a new value changes the memory an endpoint holds
  function automatic logic mem_changed(input logic [7:0] old_v, input logic [7:0] new_v);
    mem_changed = (old_v[`USBDC_CFG_EN_BIT] != new_v[`USBDC_CFG_EN_BIT])
      || (new_v[`USBDC_CFG_EN_BIT]
      && (old_v[`USBDC_CFG_SIZE_MSB:`USBDC_CFG_SIZE_LSB]
      != new_v[`USBDC_CFG_SIZE_MSB:`USBDC_CFG_SIZE_LSB]));
  endfunction : mem_changed

  //////////////////////////////////////////////////////////////////////////////
  // next state: writes, ordered sequence, bus reset
  always_comb begin
    st_d = st_q;
    st_d.alloc_start = 1'b0;
    st_d.invalidate = 1'b0;
    if (cfg_wr) begin
      st_d.cfg[cfg_idx] = cfg_wdata;
      if (mem_changed(st_q.cfg[cfg_idx], cfg_wdata)) begin
        st_d.invalidate = 1'b1;
      end
      // allocation waits for a full in-order pass ending at the last endpoint
      if (cfg_idx == `USBDC_FIRST_EP) begin
        st_d.in_order = 1'b1;
        st_d.next_ep = 5'h01;
      end else if (st_q.in_order && ({1'b0, cfg_idx} == st_q.next_ep)) begin
        st_d.next_ep = st_q.next_ep + 5'h01;
        if (cfg_idx == `USBDC_LAST_EP) begin
          st_d.alloc_start = 1'b1;
          st_d.in_order = 1'b0;
        end
      end else begin
        st_d.in_order = 1'b0;
      end
    end
    // a bus reset disables every endpoint, after any write of the same cycle
    if (bus_reset) begin
      for (int i = 0; i < 16; i++) begin
        st_d.cfg[i][`USBDC_CFG_EN_BIT] = 1'b0;
      end
      st_d.invalidate = 1'b1;
      st_d.in_order = 1'b0;
      st_d.alloc_start = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // field views of the stored configuration
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      fifo_enabled[i] = st_q.cfg[i][`USBDC_CFG_EN_BIT];
      endpoint_direction[i] = st_q.cfg[i][`USBDC_CFG_DIR_BIT];
      dma_write_dir[i] = st_q.cfg[i][`USBDC_CFG_DIR_BIT];
      double_buffered[i] = st_q.cfg[i][`USBDC_CFG_DBL_BIT];
      isochronous_select[i] = st_q.cfg[i][`USBDC_CFG_ISO_BIT];
      fifo_size_code[i*4 +: 4] = st_q.cfg[i][`USBDC_CFG_SIZE_MSB:`USBDC_CFG_SIZE_LSB];
    end
  end

  assign ep_cfg_q = st_q.cfg;
  assign fifo_alloc_start_q = st_q.alloc_start;
  assign fifo_invalidate_q = st_q.invalidate;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  cfg_store_a: assert property (cfg_wr && !bus_reset |=>
    st_q.cfg[$past(cfg_idx)] == $past(cfg_wdata))
    else $error("endpoint configuration write not stored");

  bus_reset_off_a: assert property (bus_reset |=> fifo_enabled == 16'h0000
    && fifo_invalidate_q) else $error("bus reset left an endpoint enabled");

  alloc_cause_a: assert property (fifo_alloc_start_q |->
    $past(cfg_wr) && $past(cfg_idx) == `USBDC_LAST_EP && $past(st_q.in_order))
    else $error("allocation started without a full ordered pass");

  invalidate_a: assert property (cfg_wr && mem_changed(st_q.cfg[cfg_idx], cfg_wdata)
    |=> fifo_invalidate_q) else $error("memory change did not invalidate fifos");

endmodule : usbdc_ep_cfg

//--- hdl/usbdc_pkg.sv
package usbdc_pkg;

  // phase of the command decoder
  typedef enum logic [1:0] {
    USBDC_IDLE,
    USBDC_WR,
    USBDC_RD
  } usbdc_phase_t;

  // whole state of the command decoder
  typedef struct packed {
    usbdc_phase_t phase;
    logic [7:0] cmd;
    logic [1:0] words_left;
    logic [15:0] rdata;
    logic [7:0] addr_reg;
    logic [6:0] active_addr;
    logic dev_en;
    logic addr_pending;
    logic locked;
    logic setup_ack;
    logic [15:0][7:0] err_codes;
  } usbdc_state_t;

  // whole state of the endpoint configuration store
  typedef struct packed {
    logic [15:0][7:0] cfg;
    logic [4:0] next_ep;
    logic in_order;
    logic alloc_start;
    logic invalidate;
  } usbdc_epcfg_t;

endpackage : usbdc_pkg

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_wr, data_wr, data_rd;
  logic [7:0] cmd_code;
  logic [15:0] wdata, rdata_q;
  logic bus_reset = 1'b0, status_ack = 1'b0, lock_req = 1'b0, err_wr = 1'b0;
  logic [3:0] err_idx = 4'h0;
  logic [7:0] err_code = 8'h00;
  logic [6:0] active_addr_q;
  logic setup_ack_q, device_enable_q, regs_locked_q, fifo_alloc_start_q, fifo_invalidate_q;
  logic [127:0] ep_cfg_q;
  logic [15:0] fifo_enabled, endpoint_direction, dma_write_dir, double_buffered;
  logic [15:0] isochronous_select;
  logic [63:0] fifo_size_code;
  logic [143:0] fld;
  logic [8:0] st;
  int err_total = 0, cmp_count = 0;
  // reference model
  logic [7:0] m_cfg [16];
  logic [7:0] m_err [16];
  logic [7:0] m_addr, rd_q;
  logic [6:0] m_act;
  logic m_en, m_lock, m_pend, m_inv, m_alloc;
  int pass_n;

  assign fld = {fifo_enabled, endpoint_direction, dma_write_dir, double_buffered,
    isochronous_select, fifo_size_code};
  assign st = {device_enable_q, active_addr_q, regs_locked_q};

  usbdc_cmd_decoder i_usbdc_cmd_decoder (.clk, .arst_n, .cmd_wr, .cmd_code, .data_wr, .wdata,
    .data_rd, .bus_reset, .status_ack, .lock_req, .err_wr, .err_idx, .err_code, .rdata_q,
    .setup_ack_q, .active_addr_q, .device_enable_q, .regs_locked_q, .ep_cfg_q, .fifo_enabled,
    .endpoint_direction, .dma_write_dir, .double_buffered, .isochronous_select,
    .fifo_size_code, .fifo_alloc_start_q, .fifo_invalidate_q);
  usbdc_fw_model i_usbdc_fw_model (.clk, .cmd_wr, .cmd_code, .data_wr, .wdata, .data_rd,
    .rdata_q);

  // 125 MHz clock
  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // compare, count and report
  task chk(input string n, input logic [159:0] s, input logic [159:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // all static outputs against the model
  task chk_all;
    logic [127:0] c;
    logic [143:0] f;
    for (int i = 0; i < 16; i++) begin
      c[i*8+:8] = m_cfg[i];
      f[128+i] = m_cfg[i][7];
      f[112+i] = m_cfg[i][6];
      f[96+i] = m_cfg[i][6];
      f[80+i] = m_cfg[i][5];
      f[64+i] = m_cfg[i][4];
      f[i*4+:4] = m_cfg[i][3:0];
    end
    chk("ep_cfg_q", ep_cfg_q, c);
    chk("cfg fields", fld, f);
    chk("address state", st, {m_en, m_act, m_lock});
  endtask : chk_all

  ////////////////////////////////////////////////////////////////////////////
  // operations with their expected effects
  task cfg_wr(input int i, input logic [7:0] v);
    m_inv = 1'b0;
    m_alloc = 1'b0;
    if (!m_lock) begin
      m_inv = (v[7] != m_cfg[i][7]) || (v[7] && v[3:0] != m_cfg[i][3:0]);
      pass_n = (i == 0) ? 1 : (i == pass_n) ? pass_n + 1 : 0;
      m_alloc = (pass_n == 16);
      m_cfg[i] = v;
    end
    i_usbdc_fw_model.wr(8'h20 + 8'(i), v);
    chk("invalidate", fifo_invalidate_q, m_inv);
    chk("alloc", fifo_alloc_start_q, m_alloc);
    chk_all();
  endtask : cfg_wr

  task rd_chk(input logic [7:0] c, input logic [7:0] e);
    i_usbdc_fw_model.rd(c, rd_q);
    chk("read byte", rd_q, e);
  endtask : rd_chk

  task addr_wr(input logic [7:0] v);
    i_usbdc_fw_model.wr(8'hB6, v);
    if (!m_lock) begin
      m_addr = v;
      m_pend = 1'b1;
    end
    chk_all();
  endtask : addr_wr

  // host acknowledges the empty status packet
  task host_ack;
    @(negedge clk);
    status_ack = 1'b1;
    if (m_pend) begin
      m_act = m_addr[6:0];
      m_en = m_addr[7];
    end
    m_pend = 1'b0;
    @(negedge clk);
    status_ack = 1'b0;
    chk_all();
  endtask : host_ack

  task usb_reset;
    @(negedge clk);
    bus_reset = 1'b1;
    for (int i = 0; i < 16; i++) m_cfg[i][7] = 1'b0;
    m_act = 7'h00;
    m_en = 1'b1;
    m_pend = 1'b0;
    pass_n = 0;
    @(negedge clk);
    bus_reset = 1'b0;
    chk("invalidate", fifo_invalidate_q, 1'b1);
    chk_all();
  endtask : usb_reset

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(30603));
    for (int i = 0; i < 16; i++) begin
      m_cfg[i] = 8'h00;
      m_err[i] = 8'h00;
    end
    m_addr = 8'h00;
    m_act = 7'h00;
    m_en = 1'b0;
    m_lock = 1'b0;
    m_pend = 1'b0;
    pass_n = 0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 16; i++) rd_chk(8'h30 + 8'(i), 8'h00);
    rd_chk(8'hB7, 8'h00);
    // two full passes in order, control endpoints included, then a pass missing one
    // no fifo holds data here, so nothing must be drained before reconfiguring
    repeat (2) for (int i = 0; i < 16; i++) cfg_wr(i, 8'($urandom));
    for (int i = 0; i < 16; i++) rd_chk(8'h30 + 8'(i), m_cfg[i]);
    for (int i = 0; i < 16; i++) if (i != 7) cfg_wr(i, 8'($urandom));
    cfg_wr(7, m_cfg[7] ^ 8'h80);
    cfg_wr(7, m_cfg[7] | 8'h80);
    cfg_wr(7, m_cfg[7] ^ 8'h01);
    // error codes for every endpoint, strobe held back to back
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      err_wr = 1'b1;
      err_idx = 4'(i);
      err_code = 8'($urandom);
      m_err[i] = err_code;
    end
    @(negedge clk);
    err_wr = 1'b0;
    for (int i = 0; i < 16; i++) rd_chk(8'hA0 + 8'(i), m_err[i]);
    // setup acknowledge pulse
    i_usbdc_fw_model.cmd(8'hF4);
    chk("setup ack", setup_ack_q, 1'b1);
    @(negedge clk);
    chk("setup ack", setup_ack_q, 1'b0);
    // address set, applied on acknowledge, dropped by bus reset
    addr_wr(8'h85);
    rd_chk(8'hB7, 8'h85);
    host_ack();
    addr_wr({1'b1, 7'($urandom)});
    usb_reset();
    rd_chk(8'hB7, m_addr);
    host_ack();
    // lock blocks writes, unlock with any word restores them
    @(negedge clk);
    lock_req = 1'b1;
    m_lock = 1'b1;
    @(negedge clk);
    lock_req = 1'b0;
    cfg_wr(3, ~m_cfg[3]);
    addr_wr(8'h12);
    i_usbdc_fw_model.wr(8'hB0, 8'($urandom));
    m_lock = 1'b0;
    chk_all();
    cfg_wr(3, ~m_cfg[3]);
    addr_wr(8'h93);
    host_ack();
    // codes outside this block are ignored
    i_usbdc_fw_model.wr(8'hB2, 8'h5A);
    i_usbdc_fw_model.cmd(8'h45);
    chk_all();
    test_done();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule : tb

//--- testbench/usbdc_fw_model.sv
`timescale 1ns/100ps
// firmware on the parallel port: a command code, then its data words
module usbdc_fw_model (
  input wire logic clk,
  output logic cmd_wr,
  output logic [7:0] cmd_code,
  output logic data_wr,
  output logic [15:0] wdata,
  output logic data_rd,
  input wire logic [15:0] rdata_q
);
  // idle port at time zero
  initial begin
    cmd_wr = 1'b0;
    cmd_code = 8'h00;
    data_wr = 1'b0;
    wdata = 16'h0000;
    data_rd = 1'b0;
  end

  // command phase; never a validate of OUT or a clear of IN buffers
  task cmd(input logic [7:0] c);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_code = c;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_code = ~c;
  endtask : cmd

  // write one 8-bit register, upper byte is junk
  task wr(input logic [7:0] c, input logic [7:0] d);
    cmd(c);
    for (int w = 0; w < (1 + 1) / 2; w++) begin
      data_wr = 1'b1;
      wdata = {~d, d};
      @(negedge clk);
      data_wr = 1'b0;
      wdata = ~wdata;
    end
  endtask : wr

  // read one 8-bit register, upper byte is not trusted
  task rd(input logic [7:0] c, output logic [7:0] q);
    cmd(c);
    for (int w = 0; w < (1 + 1) / 2; w++) begin
      data_rd = 1'b1;
      @(negedge clk);
      q = rdata_q[7:0];
      data_rd = 1'b0;
    end
  endtask : rd
endmodule : usbdc_fw_model
